// file: common/fbh_cfg.svh
// Constants of the flash bus host: pin widths, command codes, timing counts.
// Assumes a 100 MHz clock; times are in ns and converted to cycles here.
`ifndef FBH_CFG_SVH
`define FBH_CFG_SVH

`define FBH_ADDR_W 21
`define FBH_DATA_W 16
`define FBH_CLK_NS 10
// Cycle phases of one bus access and of the reset pulse
`define FBH_T_ACC_NS 70
`define FBH_T_ACC_CYC ((`FBH_T_ACC_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_T_WP_NS 30
`define FBH_T_WP_CYC ((`FBH_T_WP_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_T_RP_NS 500
`define FBH_T_RP_CYC ((`FBH_T_RP_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_T_RH_NS 50
`define FBH_T_RH_CYC ((`FBH_T_RH_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_CNT_W 8

// Software register offsets of the host port
`define FBH_REG_ADDR 4'h0
`define FBH_REG_WDATA 4'h1
`define FBH_REG_CMD 4'h2
`define FBH_REG_CTRL 4'h3
`define FBH_REG_STATUS 4'h4
`define FBH_REG_RDATA 4'h5
// Command register codes
`define FBH_CMD_READ 2'h0
`define FBH_CMD_WRITE 2'h1
`define FBH_CMD_RESET 2'h2
// Control fields
`define FBH_CTRL_WORD 0
`define FBH_CTRL_ACCEL 1
`define FBH_CTRL_PROT 2
// Flash command data for the unlock and id sequences
`define FBH_UNLOCK_A1 21'h000555
`define FBH_UNLOCK_A2 21'h0002aa
`define FBH_UNLOCK_D1 16'h00aa
`define FBH_UNLOCK_D2 16'h0055
// Bench flash id entry command and its id code; both values are arbitrary
`define FBH_ID_CMD 16'h0011
`define FBH_ID_CODE 16'h0a5c

`endif

// file: common/fbh_pkg.sv
// Types of the flash bus host.
// Constants live in fbh_cfg.svh.
package fbh_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RST_PULSE,
    ST_RST_RECOVER
  } fbh_state_t;
endpackage

// file: design/fbh_pin_cell.sv
// One two-way data pin cell of the flash bus host.
// Assumes the pad combines out and oe_n; oe_n low means driving.
`timescale 1ns/1ns
module fbh_pin_cell (
  input wire logic clk,
  input wire logic resetn,
  input wire logic drive,
  input wire logic val,
  input wire logic pin_in,
  input wire logic capture,
  output logic pin_out,
  output logic pin_oe_n,
  output logic cap_ff
);
  typedef struct packed {
    logic out;
    logic oe_n;
    logic cap;
  } fbh_cell_t;

  fbh_cell_t st_ff;
  fbh_cell_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.out = val;
    nxt_st.oe_n = ~drive;
    if (capture) begin
      nxt_st.cap = pin_in;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= 3'b010;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe_n = st_ff.oe_n;
  assign cap_ff = st_ff.cap;
endmodule // fbh_pin_cell

// file: design/fbh_host.sv
// Host controller that drives a dual-width flash over its parallel pins.
// Assumes synchronous pin inputs and software on a simple strobe port.
`timescale 1ns/1ns
`include "fbh_cfg.svh"

// Behaviour
// (R1) No flash address reaches command register
// (R2) Device latches command, address, data
// (R3) Read: select and gate low, strobe high
// (R4) Write: strobe and select low, gate high
// (R5) Device starts in array read mode
// (R6) Banks read array until command changes
// (R7) Width select high: sixteen data pins
// (R8) Width select low: byte lanes, top pin address
// (R9) Byte width adds low address bit
// (R10) Program width follows width select
// (R11) Short program mode: two write cycles
// (R12) Sector, multi-sector, chip erase supported
// (R13) Four banks from upper address bits
// (R14) High voltage enters short program mode
// (R15) Low protect pin guards boot sectors
// (R16) Id command gives separate id codes
// (R17) Gate high releases data pins
// (R18) Reset low aborts, device back to read
// (R19) Select high releases pins, ignores strobe
// (R20) Byte width low bit picks byte
module fbh_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic [15:0] flash_dq_oe_n,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic reset_n,
  output logic width_select_n,
  output logic protect_accel_n,
  output logic accel_high_voltage,
  input wire logic op_pending_n
);
  typedef struct packed {
    fbh_pkg::fbh_state_t state;
    logic [`FBH_CNT_W-1:0] cnt;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic [2:0] ctrl;
    logic busy;
    logic done;
    logic [15:0] rdata;
  } fbh_host_st_t;

  fbh_host_st_t st_ff;
  fbh_host_st_t nxt_st;
  logic [15:0] dq_cap;
  logic dq_drive;
  logic capture;
  logic [15:0] dq_val;
  logic [15:0] lane_drive;
  logic low_addr_bit;

  // Byte width: extra low address bit rides on the top data pin
  assign low_addr_bit = st_ff.wdata[15];
  assign dq_drive = (st_ff.state == fbh_pkg::ST_WR_PULSE) ||
                    (st_ff.state == fbh_pkg::ST_WR_HOLD); // see (R4)
  // Pins are captured one cycle before rdata takes the cell's register
  assign capture = (st_ff.state == fbh_pkg::ST_RD_SETUP) && (st_ff.cnt == `FBH_CNT_W'(1));

  always_comb begin
    dq_val = st_ff.wdata;
    lane_drive = {16{dq_drive}}; // see (R7)
    if (!st_ff.ctrl[`FBH_CTRL_WORD]) begin
      // Byte width drives only the low lane plus the address bit
      dq_val = {low_addr_bit, 7'h00, st_ff.wdata[7:0]}; // see (R8) (R9) (R10)
      lane_drive = {st_ff.state != fbh_pkg::ST_IDLE &&
                    st_ff.state != fbh_pkg::ST_RST_PULSE &&
                    st_ff.state != fbh_pkg::ST_RST_RECOVER,
                    7'h00, {8{dq_drive}}}; // see (R8)
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_dq
      fbh_pin_cell u_cell (
        .clk(clk),
        .resetn(resetn),
        .drive(lane_drive[gi]),
        .val(dq_val[gi]),
        .pin_in(flash_dq_in[gi]),
        .capture(capture),
        .pin_out(flash_dq_out[gi]),
        .pin_oe_n(flash_dq_oe_n[gi]),
        .cap_ff(dq_cap[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    // Software writes land only in host registers, never at flash addresses
    if (reg_wr) begin // see (R1)
      unique case (reg_addr)
        `FBH_REG_ADDR: nxt_st.addr[15:0] = reg_wdata;
        `FBH_REG_WDATA: nxt_st.wdata = reg_wdata;
        `FBH_REG_CTRL: begin
          nxt_st.ctrl = reg_wdata[2:0];
          nxt_st.addr[20:16] = reg_wdata[12:8]; // bank and sector bits, see (R13) (R12)
        end
        default: ;
      endcase
    end
    unique case (st_ff.state)
      fbh_pkg::ST_IDLE: begin
        nxt_st.busy = 1'b0;
        if (reg_wr && reg_addr == `FBH_REG_CMD) begin
          nxt_st.busy = 1'b1;
          unique case (reg_wdata[1:0])
            `FBH_CMD_READ: begin
              nxt_st.state = fbh_pkg::ST_RD_SETUP;
              // Spare cycle keeps the full access time before capture
              nxt_st.cnt = `FBH_CNT_W'(`FBH_T_ACC_CYC + 1);
            end
            `FBH_CMD_WRITE: begin
              nxt_st.state = fbh_pkg::ST_WR_PULSE;
              nxt_st.cnt = `FBH_CNT_W'(`FBH_T_WP_CYC);
            end
            `FBH_CMD_RESET: begin
              nxt_st.state = fbh_pkg::ST_RST_PULSE;
              nxt_st.cnt = `FBH_CNT_W'(`FBH_T_RP_CYC);
            end
            default: nxt_st.busy = 1'b0;
          endcase
        end
      end
      fbh_pkg::ST_RD_SETUP: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = fbh_pkg::ST_IDLE;
          nxt_st.done = 1'b1;
          // Byte reads: device already picked the byte by the low bit
          nxt_st.rdata = st_ff.ctrl[`FBH_CTRL_WORD] ? dq_cap
                                                  : {8'h00, dq_cap[7:0]}; // see (R20)
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      fbh_pkg::ST_WR_PULSE: begin
        // Device latches address and data at the rising strobe, see (R2)
        if (st_ff.cnt == '0) begin
          nxt_st.state = fbh_pkg::ST_WR_HOLD;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      fbh_pkg::ST_WR_HOLD: begin
        nxt_st.state = fbh_pkg::ST_IDLE;
        nxt_st.done = 1'b1;
      end
      fbh_pkg::ST_RST_PULSE: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = fbh_pkg::ST_RST_RECOVER;
          nxt_st.cnt = `FBH_CNT_W'(`FBH_T_RH_CYC);
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      fbh_pkg::ST_RST_RECOVER: begin
        // Device is back in array read after this, see (R5) (R18)
        if (st_ff.cnt == '0) begin
          nxt_st.state = fbh_pkg::ST_IDLE;
          nxt_st.done = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      default: nxt_st.state = fbh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{state: fbh_pkg::ST_IDLE, cnt: '0, addr: '0, wdata: '0,
                 ctrl: 3'h1, busy: 1'b0, done: 1'b0, rdata: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Select only during an access; idle keeps the device in standby, see (R19)
  assign chip_select_n = !(st_ff.state == fbh_pkg::ST_RD_SETUP || dq_drive);
  // Gate low only while reading, so data pins never fight, see (R3) (R17)
  assign output_gate_n = !(st_ff.state == fbh_pkg::ST_RD_SETUP);
  assign write_strobe_n = !(st_ff.state == fbh_pkg::ST_WR_PULSE); // see (R4)
  assign reset_n = !(st_ff.state == fbh_pkg::ST_RST_PULSE); // see (R18)
  assign width_select_n = st_ff.ctrl[`FBH_CTRL_WORD]; // see (R7) (R8)
  // High voltage selects short program mode; low pin keeps boot guard
  assign accel_high_voltage = st_ff.ctrl[`FBH_CTRL_ACCEL]; // see (R14) (R11)
  assign protect_accel_n = ~st_ff.ctrl[`FBH_CTRL_PROT]; // see (R15)
  assign flash_addr = st_ff.addr;

  logic [15:0] rd_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_ff <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `FBH_REG_ADDR: rd_ff <= st_ff.addr[15:0];
        `FBH_REG_WDATA: rd_ff <= st_ff.wdata;
        `FBH_REG_CTRL: rd_ff <= {3'h0, st_ff.addr[20:16], 5'h00, st_ff.ctrl};
        `FBH_REG_STATUS: rd_ff <= {13'h0000, st_ff.done, ~op_pending_n, st_ff.busy};
        `FBH_REG_RDATA: rd_ff <= st_ff.rdata; // id codes read the same way, see (R16)
        default: rd_ff <= '0;
      endcase
    end else begin
      rd_ff <= '0;
    end
  end
  assign reg_rdata = rd_ff;
endmodule // fbh_host

// file: tb/fbh_flash_model.sv
// Behavioural dual-width flash: sixteen-word array decoded by pin levels.
// Assumes the bench feeds it the host pin drivers and enables.
`timescale 1ns/1ns
`include "fbh_cfg.svh"
module fbh_flash_model (
  input wire logic [20:0] a,
  input wire logic [15:0] hd,
  input wire logic [15:0] hoe_n,
  input wire logic cs_n,
  input wire logic og_n,
  input wire logic ws_n,
  input wire logic rst_n,
  input wire logic byte_n,
  output logic [15:0] dq,
  output logic rdy_n
);
  logic [15:0] mem [16];
  logic [15:0] rdv;
  logic drv;
  logic id_mode;
  // The array is mapped; an id command write at the unlock address sets the id latch instead
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h1234 ^ {4{i[3:0]}};
  initial id_mode = 1'b0;
  // Busy while its own reset runs, so the host status bit moves
  assign rdy_n = rst_n;
  assign drv = !cs_n && !og_n && ws_n && rst_n;
  always_comb begin
    // Id codes come from a register apart from the array
    rdv = id_mode ? `FBH_ID_CODE : mem[a[3:0]];
    if (!byte_n) rdv = {8'h00, hd[15] ? rdv[15:8] : rdv[7:0]};
    // Released lines show the inverse, so stale data cannot pass
    for (int i = 0; i < 16; i++) begin
      dq[i] = !hoe_n[i] ? hd[i] : (drv && (byte_n || i < 8)) ? rdv[i] : ~rdv[i];
    end
  end
  always @(posedge ws_n or negedge rst_n) begin
    if (!rst_n) begin
      id_mode = 1'b0;
    end else if (!cs_n && og_n) begin
      if (a == `FBH_UNLOCK_A1 && hd == `FBH_ID_CMD) begin
        id_mode = 1'b1;
      end else begin
        mem[a[3:0]] = hd;
      end
    end
  end
endmodule // fbh_flash_model

// file: tb/fbh_host_chk.sv
// Checker of the host pin levels of the flash bus.
// Assumes one clock domain; bound to fbh_host.
`timescale 1ns/1ns
`include "fbh_cfg.svh"
module fbh_host_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_oe_n,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic reset_n,
  input wire logic width_select_n,
  input wire logic protect_accel_n,
  input wire logic accel_high_voltage
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_read_levels: assert property (
    !output_gate_n |-> write_strobe_n && !chip_select_n)
    else $error("gate low outside read");
  chk_write_levels: assert property (
    !write_strobe_n |-> output_gate_n && !chip_select_n)
    else $error("strobe low outside write");
  // Byte width keeps the top pin driven: it carries the low address bit
  chk_read_release: assert property (
    !output_gate_n |-> &flash_dq_oe_n[14:0] && (!width_select_n || flash_dq_oe_n[15]))
    else $error("host drives during read");
  chk_byte_lanes: assert property (!width_select_n |-> &flash_dq_oe_n[14:8])
    else $error("upper lanes driven in byte width");
  chk_idle_quiet: assert property (
    chip_select_n |-> write_strobe_n && output_gate_n)
    else $error("strobe while deselected");
  chk_reset_quiet: assert property (!reset_n |-> chip_select_n)
    else $error("select during reset");
  chk_reset_len: assert property ($fell(reset_n) |-> !reset_n [*8])
    else $error("reset pulse short");
  chk_wr_pulse: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3])
    else $error("write pulse short");
  chk_wr_drive: assert property (
    $fell(write_strobe_n) |-> ##[1:2] !flash_dq_oe_n[0])
    else $error("write data not driven");
  chk_ctrl_pins: assert property (
    reg_wr && reg_addr == `FBH_REG_CTRL |=>
      width_select_n == $past(reg_wdata[`FBH_CTRL_WORD]) &&
      accel_high_voltage == $past(reg_wdata[`FBH_CTRL_ACCEL]) &&
      protect_accel_n == !$past(reg_wdata[`FBH_CTRL_PROT]))
    else $error("control pins differ from control write");
  chk_bank_bits: assert property (
    reg_wr && reg_addr == `FBH_REG_CTRL |=> flash_addr[20:16] == $past(reg_wdata[12:8]))
    else $error("bank and sector bits differ from control write");
  chk_low_addr: assert property (
    reg_wr && reg_addr == `FBH_REG_ADDR |=> flash_addr[15:0] == $past(reg_wdata))
    else $error("address pins differ from address write");
endmodule // fbh_host_chk
bind fbh_host fbh_host_chk u_fbh_host_chk (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .flash_addr(flash_addr),
  .flash_dq_oe_n(flash_dq_oe_n), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
  .write_strobe_n(write_strobe_n), .reset_n(reset_n), .width_select_n(width_select_n),
  .protect_accel_n(protect_accel_n), .accel_high_voltage(accel_high_voltage));

// file: tb/testbench.sv
// Self-checking bench: software port stimulus, flash model on the pins.
// Assumes the register map and command codes of fbh_cfg.svh.
`timescale 1ns/1ns
`include "fbh_cfg.svh"
module testbench;
  logic clk, resetn, reg_wr, reg_rd, want, pend, cs_n, og_n, ws_n, rs_n, by_n, rdy_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dq_out, dq_oe_n, dq_in, d, d0, c0, q[$];
  logic [20:0] fa;
  int fails, total_checks;
  fbh_host u_fbh_host (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa),
    .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .chip_select_n(cs_n),
    .output_gate_n(og_n), .write_strobe_n(ws_n), .reset_n(rs_n), .width_select_n(by_n),
    .protect_accel_n(), .accel_high_voltage(), .op_pending_n(rdy_n));
  fbh_flash_model u_fbh_flash_model (.a(fa), .hd(dq_out), .hoe_n(dq_oe_n), .cs_n(cs_n),
    .og_n(og_n), .ws_n(ws_n), .rst_n(rs_n), .byte_n(by_n), .dq(dq_in), .rdy_n(rdy_n));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] f(input logic [3:0] a);
    return 16'h1234 ^ {4{a}};
  endfunction
  task automatic cmp(input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD reg_rdata exp %h got %h", e, s);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    reg_rd <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic w, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    reg_wr <= 0;
    want <= w;
    if (w) q.push_back(e);
    @(posedge clk);
  endtask
  // Busy is polled, never a fixed wait
  task automatic op(input logic [1:0] c);
    int n;
    wr(`FBH_REG_CMD, 16'(c));
    // A reset pulse also shows the device busy bit
    rd(`FBH_REG_STATUS, 1, (c == `FBH_CMD_RESET) ? 16'h0003 : 16'h0001);
    // Each edge shows the status of the read strobed one cycle before
    for (n = 0; n < 300; n++) begin
      rd(`FBH_REG_STATUS, 0, 0);
      if (reg_rdata[0] === 1'b0) break;
    end
    if (n == 300) begin
      fails++;
      conclude();
    end
  endtask
  always @(posedge clk) begin
    if (pend === 1'b1) cmp(q.pop_front(), reg_rdata);
    pend <= reg_rd && want;
  end
  initial begin
    resetn = 0;
    reg_wr = 0;
    reg_rd = 0;
    want = 0;
    reg_addr = 0;
    reg_wdata = 0;
    void'($urandom(32'h680a));
    repeat (3) @(posedge clk);
    resetn <= 1;
    rd(4'h7, 1, 16'h0000);
    // Random bank, sector and pin bits; word width kept
    c0 = 16'h0001 | (16'($urandom) & 16'h1f06);
    wr(`FBH_REG_CTRL, c0);
    rd(`FBH_REG_CTRL, 1, c0);
    wr(`FBH_REG_ADDR, 16'h0009);
    op(`FBH_CMD_READ);
    rd(`FBH_REG_RDATA, 1, f(4'h9));
    for (int k = 0; k < 3; k++) begin
      d = 16'($urandom);
      if (k == 0) d0 = d;
      wr(`FBH_REG_ADDR, 16'(k));
      wr(`FBH_REG_WDATA, d);
      op(`FBH_CMD_WRITE);
      op(`FBH_CMD_READ);
      rd(`FBH_REG_RDATA, 1, d);
    end
    d = f(4'h5);
    wr(`FBH_REG_CTRL, 16'h0000);
    wr(`FBH_REG_ADDR, 16'h0005);
    for (int k = 0; k < 2; k++) begin
      wr(`FBH_REG_WDATA, 16'(k) << 15);
      op(`FBH_CMD_READ);
      rd(`FBH_REG_RDATA, 1, {8'h00, k ? d[15:8] : d[7:0]});
    end
    wr(`FBH_REG_CTRL, 16'h0001);
    // Id entry hides the array until the reset pulse brings it back
    wr(`FBH_REG_ADDR, 16'(`FBH_UNLOCK_A1));
    wr(`FBH_REG_WDATA, `FBH_ID_CMD);
    op(`FBH_CMD_WRITE);
    wr(`FBH_REG_ADDR, 16'h0000);
    op(`FBH_CMD_READ);
    rd(`FBH_REG_RDATA, 1, `FBH_ID_CODE);
    op(`FBH_CMD_RESET);
    op(`FBH_CMD_READ);
    rd(`FBH_REG_RDATA, 1, d0);
    reg_rd <= 0;
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule // testbench
